//--- hw/bipm_idle_unit.sv
// Idle power-down unit: strobe watch, fifteen period counter, power-down flag
`timescale 1ns/1ps
`default_nettype none
module bipm_idle_unit
    import bipm_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic clk_tick_in,
    input wire logic strobe_in,
    input wire logic strobe_idle_level_in,
    input wire logic enable_in,
    input wire logic chip_sel_n_in,
    output logic power_down_out
);
    logic [IDLE_CNT_W-1:0] count_ff;
    logic [IDLE_CNT_W-1:0] nxt_count;
    logic strobe_prev_ff;
    logic nxt_strobe_prev;
    bipm_state_e state_ff;
    bipm_state_e nxt_state;
    logic strobe_act;
    localparam logic [IDLE_CNT_W-1:0] CNT_LAST = IDLE_CNT_W'(IDLE_PERIODS);
    // Activity is any strobe edge or the strobe sitting at its active level
    assign strobe_act = (strobe_in != strobe_prev_ff) || (strobe_in != strobe_idle_level_in);
    // Counter and flag next values
    always_comb
    begin
        nxt_count = count_ff;
        nxt_state = state_ff;
        nxt_strobe_prev = strobe_in;
        if (strobe_act)
        begin
            nxt_count = '0;
        end
        else if (enable_in && clk_tick_in && count_ff != CNT_LAST)
        begin
            nxt_count = count_ff + 1'b1;
        end
        unique case (state_ff)
            BIPM_RUN:
            begin
                if (enable_in && !strobe_act && clk_tick_in && count_ff == CNT_LAST - 1'b1)
                begin
                    nxt_state = BIPM_DOWN;
                end
            end
            BIPM_DOWN:
            begin
                if (strobe_act || !chip_sel_n_in || !enable_in)
                begin
                    nxt_state = BIPM_RUN;
                    nxt_count = '0;
                end
            end
        endcase
        if (!rst_n_in)
        begin
            nxt_count = '0;
            nxt_state = BIPM_RUN;
            nxt_strobe_prev = strobe_idle_level_in;
        end
    end
    // Register idle state
    always_ff @(posedge mclk_in)
    begin
        count_ff <= nxt_count;
        state_ff <= nxt_state;
        strobe_prev_ff <= nxt_strobe_prev;
    end
    assign power_down_out = (state_ff == BIPM_DOWN);
endmodule // bipm_idle_unit
`default_nettype wire

//--- hw/bipm_pkg.sv
// Constants, field positions and state codes for the bus idle power manager
// Notes on behaviour
// - Idle strobe for the idle period with the feature enabled enters power-down.
// - In power-down, host address and data are blocked and memories deselected.
// - Memories stay standby in power-down; unblocked changing PLD inputs keep PLDs awake.
// - Port D bit 2 is active-low chip select; high disables flash, SRAM, I/O select.
// - Chip select high puts memories in standby but does not block or disable PLDs.
// - First access after chip select becomes active may take slightly longer.
// - Port D bit 1 is the common clock for PLD logic and idle counter.
// - Port D bit 0 is the address strobe input watched by the idle monitor.
// - Port D bit 3 is active-low high-byte write or byte enable input.
// - Host may write power mode registers anytime; each blocking bit blocks its PLD signal.
// - Blockable PLD inputs: low address byte, three control lines, strobe, high-byte write.
// - PLD full speed is on by default; setting its control bit disables it.
// - Full speed off lets PLDs idle when inputs are stable; on draws constant current.
// - Memories stand by while inputs are stable; wake and latch on any change.
// - Strobe inactive fifteen common clock periods with feature enabled raises power-down.
// - Strobe pulsing, chip select low or reset assertion leave power-down.
// - First power mode register bit 1 enables idle power-down.
// - First power mode register bit 3 set turns PLD full speed off.
package bipm_pkg;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int REG_W = 8;
    localparam int PM0_IDLE_EN_BIT = 1;
    localparam int PM0_FULL_SPEED_OFF_BIT = 3;
    localparam int PM0_CLK_BLOCK_BIT = 4;
    localparam int PM2_ADDR_BLOCK_BIT = 0;
    localparam int PM2_CNTL0_BLOCK_BIT = 2;
    localparam int PM2_CNTL1_BLOCK_BIT = 3;
    localparam int PM2_CNTL2_BLOCK_BIT = 4;
    localparam int PM2_STROBE_BLOCK_BIT = 5;
    localparam int PM2_WRH_BLOCK_BIT = 6;
    localparam logic [7:0] PM_RESET = 8'h00;
    localparam logic [7:0] PM0_WRITE_MASK = 8'h1a;
    localparam logic [7:0] PM2_WRITE_MASK = 8'h7d;
    // ************************************************************
    // Timing, widths and state codes
    // ************************************************************
    localparam int IDLE_PERIODS = 15;
    localparam int IDLE_CNT_W = 4;
    localparam int WAKE_PENALTY_CYCLES = 1;
    localparam int CNTL_W = 3;
    localparam int ADDR_LO_W = 8;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;
    typedef enum logic [0:0] {
        BIPM_RUN = 1'b0,
        BIPM_DOWN = 1'b1
    } bipm_state_e;
endpackage

//--- hw/bipm_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module bipm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;
    // Next values of both stages
    always_comb
    begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
        if (!rst_n_in)
        begin
            nxt_meta = '0;
            nxt_sync = '0;
        end
    end
    // Register both stages
    always_ff @(posedge mclk_in)
    begin
        meta_ff <= nxt_meta;
        sync_ff <= nxt_sync;
    end
    assign sync_out = sync_ff;
endmodule // bipm_sync
`default_nettype wire

//--- hw/bipm_top.sv
// Bus idle power manager top: pin sync, power mode registers, gating
`timescale 1ns/1ps
`default_nettype none
module bipm_top
    import bipm_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W,
    parameter int DATA_WIDTH = DATA_W
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,

    // Port D pins
    input wire logic port_d_bit0_in,
    input wire logic port_d_bit1_in,
    input wire logic port_d_bit2_in,
    input wire logic port_d_bit3_in,

    // Pin function assignment straps
    input wire logic strobe_sel_in,
    input wire logic common_clock_sel_in,
    input wire logic chip_sel_sel_in,
    input wire logic high_write_sel_in,
    input wire logic byte_enable_mode_in,
    input wire logic strobe_idle_level_in,

    // Host bus
    input wire logic [ADDR_WIDTH-1:0] host_addr_in,
    input wire logic [DATA_WIDTH-1:0] host_data_in,
    input wire logic [CNTL_W-1:0] bus_control_inputs_in,
    input wire logic flash_sel_in,
    input wire logic sram_sel_in,
    input wire logic io_sel_in,

    // Power mode register writes
    input wire logic pm_first_wr_in,
    input wire logic pm_second_wr_in,
    input wire logic [REG_W-1:0] pm_wdata_in,

    // Outputs
    output logic [REG_W-1:0] power_mode_reg_first_out,
    output logic [REG_W-1:0] power_mode_reg_second_out,
    output logic power_down_flag_out,
    output logic [ADDR_WIDTH-1:0] mem_addr_out,
    output logic [DATA_WIDTH-1:0] mem_data_out,
    output logic flash_sel_out,
    output logic sram_sel_out,
    output logic io_register_select_out,
    output logic mem_standby_out,
    output logic first_access_slow_out,
    output logic [ADDR_LO_W-1:0] pld_addr_out,
    output logic [CNTL_W-1:0] pld_cntl_out,
    output logic pld_strobe_out,
    output logic pld_high_write_out,
    output logic pld_clock_out,
    output logic pld_full_speed_out,
    output logic pld_standby_out
);
    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (ADDR_WIDTH < ADDR_LO_W) begin : g_bad_addr
        $error("ADDR_WIDTH must be at least ADDR_LO_W");
    end
    if (DATA_WIDTH < 1) begin : g_bad_data
        $error("DATA_WIDTH must be positive");
    end

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [3:0] pd_sync;
    bipm_sync #(.WIDTH(4)) u_sync (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .async_in({port_d_bit3_in, port_d_bit2_in, port_d_bit1_in, port_d_bit0_in}),
        .sync_out(pd_sync)
    );

    logic strobe;
    logic common_clock_in;
    logic chip_sel_n;
    logic write_high_byte_n;
    logic byte_enable_strobe;

    assign strobe = strobe_sel_in ? pd_sync[0] : strobe_idle_level_in;
    assign common_clock_in = common_clock_sel_in & pd_sync[1];
    assign chip_sel_n = chip_sel_sel_in ? pd_sync[2] : 1'b0;
    assign write_high_byte_n = high_write_sel_in ? pd_sync[3] : 1'b1;
    assign byte_enable_strobe = byte_enable_mode_in ? ~write_high_byte_n : 1'b0;

    // ************************************************************
    // Common clock rise detect as one-cycle enable
    // ************************************************************
    logic clk_prev_ff;
    logic nxt_clk_prev;
    logic clk_tick;
    assign clk_tick = common_clock_in & ~clk_prev_ff;

    // ************************************************************
    // Power mode registers
    // ************************************************************
    logic [REG_W-1:0] pm0_ff;
    logic [REG_W-1:0] pm2_ff;
    logic [REG_W-1:0] nxt_pm0;
    logic [REG_W-1:0] nxt_pm2;
    logic power_down;
    bipm_idle_unit u_idle (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .clk_tick_in(clk_tick),
        .strobe_in(strobe),
        .strobe_idle_level_in(strobe_idle_level_in),
        .enable_in(pm0_ff[PM0_IDLE_EN_BIT]),
        .chip_sel_n_in(chip_sel_n),
        .power_down_out(power_down)
    );

    // Register next values; written at any time
    always_comb
    begin
        nxt_pm0 = pm0_ff;
        nxt_pm2 = pm2_ff;
        nxt_clk_prev = common_clock_in;

        if (pm_first_wr_in)
        begin
            nxt_pm0 = pm_wdata_in & PM0_WRITE_MASK;
        end

        if (pm_second_wr_in)
        begin
            nxt_pm2 = pm_wdata_in & PM2_WRITE_MASK;
        end

        if (!rst_n_in)
        begin
            nxt_pm0 = PM_RESET;
            nxt_pm2 = PM_RESET;
            nxt_clk_prev = 1'b0;
        end
    end

    // Register mode registers and clock history
    always_ff @(posedge mclk_in)
    begin
        pm0_ff <= nxt_pm0;
        pm2_ff <= nxt_pm2;
        clk_prev_ff <= nxt_clk_prev;
    end

    // ************************************************************
    // Output gating
    // ************************************************************
    logic [ADDR_WIDTH-1:0] addr_ff;
    logic [ADDR_WIDTH-1:0] nxt_addr;
    logic [DATA_WIDTH-1:0] data_ff;
    logic [DATA_WIDTH-1:0] nxt_data;
    logic [ADDR_LO_W-1:0] paddr_ff;
    logic [ADDR_LO_W-1:0] nxt_paddr;
    logic [CNTL_W-1:0] pcntl_ff;
    logic [CNTL_W-1:0] nxt_pcntl;
    logic fsel_ff;
    logic nxt_fsel;
    logic ssel_ff;
    logic nxt_ssel;
    logic iosel_ff;
    logic nxt_iosel;
    logic mstb_ff;
    logic nxt_mstb;
    logic slow_ff;
    logic nxt_slow;
    logic pstr_ff;
    logic nxt_pstr;
    logic pwrh_ff;
    logic nxt_pwrh;
    logic pclk_ff;
    logic nxt_pclk;
    logic pfull_ff;
    logic nxt_pfull;
    logic pstb_ff;
    logic nxt_pstb;
    logic pdn_ff;
    logic nxt_pdn;
    logic csn_prev_ff;
    logic nxt_csn_prev;
    logic pld_change;

    // Any unblocked PLD input changing versus its last registered value
    assign pld_change = (nxt_paddr != paddr_ff) || (nxt_pcntl != pcntl_ff)
        || (nxt_pstr != pstr_ff) || (nxt_pwrh != pwrh_ff) || (nxt_pclk != pclk_ff);

    always_comb
    begin
        nxt_addr = power_down ? addr_ff : host_addr_in;
        nxt_data = power_down ? data_ff : host_data_in;

        // chip select high disables memories and I/O select
        // chip select does not touch PLD paths
        nxt_fsel = flash_sel_in & ~power_down & ~chip_sel_n;
        nxt_ssel = sram_sel_in & ~power_down & ~chip_sel_n;
        nxt_iosel = io_sel_in & ~power_down & ~chip_sel_n;

        // memories stand by while inputs are stable
        // memories stay standby in power-down whatever the bus does
        nxt_mstb = power_down || chip_sel_n
            || ((nxt_addr == addr_ff) && (nxt_data == data_ff));

        // first access after select may take longer
        nxt_slow = csn_prev_ff & ~chip_sel_n;
        nxt_csn_prev = chip_sel_n;

        nxt_paddr = pm2_ff[PM2_ADDR_BLOCK_BIT] || power_down ? paddr_ff : host_addr_in[ADDR_LO_W-1:0];
        nxt_pcntl = pcntl_ff;
        if (!power_down)
        begin
            nxt_pcntl[0] = pm2_ff[PM2_CNTL0_BLOCK_BIT] ? pcntl_ff[0] : bus_control_inputs_in[0];
            nxt_pcntl[1] = pm2_ff[PM2_CNTL1_BLOCK_BIT] ? pcntl_ff[1] : bus_control_inputs_in[1];
            nxt_pcntl[2] = pm2_ff[PM2_CNTL2_BLOCK_BIT] ? pcntl_ff[2] : bus_control_inputs_in[2];
        end

        nxt_pstr = pm2_ff[PM2_STROBE_BLOCK_BIT] || power_down ? pstr_ff : strobe;
        nxt_pwrh = pm2_ff[PM2_WRH_BLOCK_BIT] || power_down ? pwrh_ff
            : (byte_enable_mode_in ? byte_enable_strobe : write_high_byte_n);

        // Clock to PLDs blockable; idle unit sees it regardless
        nxt_pclk = pm0_ff[PM0_CLK_BLOCK_BIT] ? pclk_ff : common_clock_in;

        // full speed on unless bit set
        // bit 3 turns full speed off
        nxt_pfull = ~pm0_ff[PM0_FULL_SPEED_OFF_BIT];

        // standby only when full speed off and inputs stable
        nxt_pstb = pm0_ff[PM0_FULL_SPEED_OFF_BIT] & ~pld_change;

        nxt_pdn = power_down;

        if (!rst_n_in)
        begin
            nxt_addr = '0;
            nxt_data = '0;
            nxt_fsel = 1'b0;
            nxt_ssel = 1'b0;
            nxt_iosel = 1'b0;
            nxt_mstb = 1'b1;
            nxt_slow = 1'b0;
            nxt_csn_prev = 1'b0;
            nxt_paddr = '0;
            nxt_pcntl = '0;
            nxt_pstr = 1'b0;
            nxt_pwrh = 1'b0;
            nxt_pclk = 1'b0;
            nxt_pfull = 1'b1;
            nxt_pstb = 1'b0;
            nxt_pdn = 1'b0;
        end
    end

    // Register the gated outputs
    always_ff @(posedge mclk_in)
    begin
        addr_ff <= nxt_addr;
        data_ff <= nxt_data;
        fsel_ff <= nxt_fsel;
        ssel_ff <= nxt_ssel;
        iosel_ff <= nxt_iosel;
        mstb_ff <= nxt_mstb;
        slow_ff <= nxt_slow;
        csn_prev_ff <= nxt_csn_prev;
        paddr_ff <= nxt_paddr;
        pcntl_ff <= nxt_pcntl;
        pstr_ff <= nxt_pstr;
        pwrh_ff <= nxt_pwrh;
        pclk_ff <= nxt_pclk;
        pfull_ff <= nxt_pfull;
        pstb_ff <= nxt_pstb;
        pdn_ff <= nxt_pdn;
    end

    // Outputs straight from their flip-flops
    assign power_mode_reg_first_out = pm0_ff;
    assign power_mode_reg_second_out = pm2_ff;
    assign power_down_flag_out = pdn_ff;
    assign mem_addr_out = addr_ff;
    assign mem_data_out = data_ff;
    assign flash_sel_out = fsel_ff;
    assign sram_sel_out = ssel_ff;
    assign io_register_select_out = iosel_ff;
    assign mem_standby_out = mstb_ff;
    assign first_access_slow_out = slow_ff;
    assign pld_addr_out = paddr_ff;
    assign pld_cntl_out = pcntl_ff;
    assign pld_strobe_out = pstr_ff;
    assign pld_high_write_out = pwrh_ff;
    assign pld_clock_out = pclk_ff;
    assign pld_full_speed_out = pfull_ff;
    assign pld_standby_out = pstb_ff;
endmodule // bipm_top
`default_nettype wire

//--- tb/bipm_host_model.sv
// Host side model: strobe, common clock, chip select and bus traffic
`timescale 1ns/1ps
`default_nettype none
module bipm_host_model (
    input wire logic mclk_in,
    input wire logic busy_in,
    input wire logic move_in,
    input wire logic cs_n_in,
    output logic strobe_out,
    output logic cclk_out,
    output logic cs_pin_out,
    output logic [15:0] addr_out,
    output logic [15:0] data_out,
    output logic [2:0] cntl_out
);
    logic [1:0] div_ff;
    initial
    begin
        div_ff = 2'h0;
        strobe_out = 1'b0;
        cclk_out = 1'b0;
        cs_pin_out = 1'b1;
        addr_out = 16'h0000;
        data_out = 16'h0000;
        cntl_out = 3'h0;
    end
    // common clock: free running, four system cycles a period
    // strobe: toggles while busy, rests at its idle level otherwise
    // bus noise: address and data may keep moving while idle
    always @(negedge mclk_in)
    begin
        div_ff <= div_ff + 2'h1;
        cclk_out <= div_ff[1];
        strobe_out <= busy_in ? ~strobe_out : 1'b0;
        cs_pin_out <= cs_n_in;
        if (move_in)
        begin
            addr_out <= 16'($urandom);
            data_out <= 16'($urandom);
            cntl_out <= 3'($urandom);
        end
    end
endmodule // bipm_host_model
`default_nettype wire

//--- tb/bipm_top_props.sv
// Concurrent checks on the ports of the bus idle power manager top
`timescale 1ns/1ps
`default_nettype none
module bipm_top_props
    import bipm_pkg::*;
#(
    parameter int ADDR_WIDTH = 16,
    parameter int DATA_WIDTH = 16
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic port_d_bit0_in,
    input wire logic strobe_sel_in,
    input wire logic pm_first_wr_in,
    input wire logic pm_second_wr_in,
    input wire logic [REG_W-1:0] pm_wdata_in,
    input wire logic [REG_W-1:0] power_mode_reg_first_out,
    input wire logic [REG_W-1:0] power_mode_reg_second_out,
    input wire logic power_down_flag_out,
    input wire logic [ADDR_WIDTH-1:0] mem_addr_out,
    input wire logic [ADDR_LO_W-1:0] pld_addr_out,
    input wire logic flash_sel_out,
    input wire logic sram_sel_out,
    input wire logic io_register_select_out,
    input wire logic mem_standby_out,
    input wire logic pld_full_speed_out,
    input wire logic first_access_slow_out
);
    logic prev_ff;
    logic nxt_prev;
    logic [5:0] quiet_ff;
    logic [5:0] nxt_quiet;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // ************************************************************
    // Strobe quiet counter
    // ************************************************************
    // Cycles since the strobe pin last moved, saturating
    always_comb
    begin
        nxt_prev = port_d_bit0_in;
        nxt_quiet = quiet_ff;
        if (port_d_bit0_in != prev_ff)
            nxt_quiet = 6'h00;
        else if (quiet_ff != 6'h3f)
            nxt_quiet = quiet_ff + 6'h01;
        if (!rst_n_in)
            nxt_quiet = 6'h00;
    end
    // Registers the counter
    always_ff @(posedge mclk_in)
    begin
        prev_ff <= nxt_prev;
        quiet_ff <= nxt_quiet;
    end
    // ************************************************************
    // Properties
    // ************************************************************
    sequence strobe_moves_s;
        $changed(port_d_bit0_in) ##1 $changed(port_d_bit0_in);
    endsequence
    sequence pd_seen_s;
        power_down_flag_out && strobe_sel_in;
    endsequence
    first_reg_write_a: assert property (pm_first_wr_in |=> power_mode_reg_first_out == ($past(pm_wdata_in) & 8'h1a)) else $error("first mode register write mismatch");
    second_reg_write_a: assert property (pm_second_wr_in |=> power_mode_reg_second_out == ($past(pm_wdata_in) & 8'h7d)) else $error("second mode register write mismatch");
    reg_hold_a: assert property (!pm_first_wr_in && !pm_second_wr_in |=> $stable(power_mode_reg_first_out) && $stable(power_mode_reg_second_out)) else $error("mode register changed without write");
    full_speed_map_a: assert property (pld_full_speed_out == !$past(power_mode_reg_first_out[3])) else $error("full speed does not follow its bit");
    pd_entry_sel_a: assert property ($rose(power_down_flag_out) |-> !flash_sel_out && !sram_sel_out && !io_register_select_out && mem_standby_out) else $error("memories selected in power-down");
    pd_bus_hold_a: assert property (power_down_flag_out |-> $stable(mem_addr_out) && $stable(pld_addr_out)) else $error("address passed in power-down");
    pd_needs_enable_a: assert property ($rose(power_down_flag_out) |-> power_mode_reg_first_out[1]) else $error("power-down while disabled");
    pd_quiet_a: assert property ($rose(power_down_flag_out) && strobe_sel_in |-> quiet_ff >= 6'd15) else $error("power-down before idle period");
    strobe_wake_a: assert property (pd_seen_s ##0 strobe_moves_s |-> ##[1:8] !power_down_flag_out) else $error("strobe activity did not wake");
    slow_pulse_a: assert property (first_access_slow_out |=> !first_access_slow_out) else $error("slow access flag longer than one cycle");
endmodule // bipm_top_props
`default_nettype wire

//--- tb/bus_idle_power_manager_bench.sv
// Self-checking bench for the bus idle power manager
`timescale 1ns/1ps
`default_nettype none
module bus_idle_power_manager_bench;
    import bipm_pkg::*;
    logic mclk_in, rst_n_in, busy, move, cs_n;
    logic port_d_bit0_in, port_d_bit1_in, port_d_bit2_in, strobe_sel_in, common_clock_sel_in;
    logic chip_sel_sel_in, high_write_sel_in, byte_enable_mode_in, strobe_idle_level_in;
    logic [15:0] host_addr_in, host_data_in;
    logic [2:0] bus_control_inputs_in, pld_cntl_out, held3;
    logic flash_sel_in, sram_sel_in, io_sel_in, pm_first_wr_in, pm_second_wr_in;
    logic [7:0] pm_wdata_in, power_mode_reg_first_out, power_mode_reg_second_out, pld_addr_out, v;
    logic power_down_flag_out, flash_sel_out, io_register_select_out, mem_standby_out;
    logic first_access_slow_out, pld_full_speed_out, pld_standby_out, sram_sel_out;
    logic [15:0] mem_addr_out, held;
    int err_total, n_tests, n;
    bipm_host_model host (.mclk_in, .busy_in(busy), .move_in(move), .cs_n_in(cs_n),
        .strobe_out(port_d_bit0_in), .cclk_out(port_d_bit1_in), .cs_pin_out(port_d_bit2_in),
        .addr_out(host_addr_in), .data_out(host_data_in), .cntl_out(bus_control_inputs_in));
    bipm_top dut (.mclk_in, .rst_n_in, .port_d_bit0_in, .port_d_bit1_in, .port_d_bit2_in,
        .port_d_bit3_in(host_data_in[0]), .strobe_sel_in, .common_clock_sel_in,
        .chip_sel_sel_in, .high_write_sel_in, .byte_enable_mode_in, .strobe_idle_level_in,
        .host_addr_in, .host_data_in, .bus_control_inputs_in, .flash_sel_in, .sram_sel_in,
        .io_sel_in, .pm_first_wr_in, .pm_second_wr_in, .pm_wdata_in,
        .power_mode_reg_first_out, .power_mode_reg_second_out, .power_down_flag_out,
        .mem_addr_out, .mem_data_out(), .flash_sel_out, .sram_sel_out, .io_register_select_out,
        .mem_standby_out, .first_access_slow_out, .pld_addr_out, .pld_cntl_out,
        .pld_strobe_out(), .pld_high_write_out(), .pld_clock_out(), .pld_full_speed_out,
        .pld_standby_out);
    // ************************************************************
    // Helpers
    // ************************************************************
    // Clock of 10 ns
    initial
    begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("errors %0d checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic pm_write(input logic second, input logic [7:0] val);
        @(negedge mclk_in);
        pm_wdata_in = val;
        pm_first_wr_in = !second;
        pm_second_wr_in = second;
        @(negedge mclk_in);
        pm_first_wr_in = 1'b0;
        pm_second_wr_in = 1'b0;
    endtask
    task automatic wait_pd(input logic lvl, input int lim);
        n = 0;
        while (power_down_flag_out !== lvl && n < lim)
        begin
            @(negedge mclk_in);
            n++;
        end
    endtask
    function automatic logic [7:0] masked(input logic second, input logic [7:0] x);
        return x & (second ? 8'h7d : 8'h1a);
    endfunction
    // Watchdog against a hang
    initial
    begin
        #200000;
        err_total++;
        close_out();
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        {rst_n_in, busy, move, cs_n, pm_first_wr_in, pm_second_wr_in, pm_wdata_in} = '0;
        {strobe_sel_in, common_clock_sel_in, chip_sel_sel_in, high_write_sel_in} = 4'hf;
        {byte_enable_mode_in, strobe_idle_level_in} = 2'h0;
        {flash_sel_in, sram_sel_in, io_sel_in} = 3'h7;
        err_total = 0;
        n_tests = 0;
        void'($urandom(32'h1ca9));
        repeat (8) @(negedge mclk_in);
        rst_n_in = 1'b1;
        check(power_mode_reg_first_out, 8'h00);
        check(pld_full_speed_out, 1'b1);
        // Random and corner writes to both mode registers
        for (int i = 0; i < 8; i++)
        begin
            v = (i < 2) ? 8'hff : 8'($urandom);
            pm_write(i[0], v);
            @(negedge mclk_in);
            check(i[0] ? power_mode_reg_second_out : power_mode_reg_first_out, masked(i[0], v));
            if (!i[0])
                check(pld_full_speed_out, !v[3]);
            if (i == 0)
                check(pld_standby_out, 1'b1);
        end
        pm_write(1'b1, 8'h00);
        pm_write(1'b0, 8'h00);
        // Deselected chip: memories off, PLD path alive
        cs_n = 1'b1;
        move = 1'b1;
        repeat (4) @(negedge mclk_in);
        move = 1'b0;
        repeat (6) @(negedge mclk_in);
        check(flash_sel_out, 1'b0);
        check(io_register_select_out, 1'b0);
        check(sram_sel_out, 1'b0);
        check(pld_standby_out, 1'b0);
        check(pld_addr_out, host_addr_in[7:0]);
        cs_n = 1'b0;
        n = 0;
        repeat (8)
        begin
            @(negedge mclk_in);
            n += first_access_slow_out;
        end
        check(n[15:0], 16'd1);
        check(flash_sel_out, 1'b1);
        // Blocking of the low address and control inputs
        pm_write(1'b1, 8'h1d);
        repeat (2) @(negedge mclk_in);
        v = pld_addr_out;
        held3 = pld_cntl_out;
        move = 1'b1;
        repeat (5) @(negedge mclk_in);
        move = 1'b0;
        repeat (4) @(negedge mclk_in);
        check(pld_addr_out, v);
        check(pld_cntl_out, held3);
        pm_write(1'b1, 8'h00);
        repeat (4) @(negedge mclk_in);
        check(pld_cntl_out, bus_control_inputs_in);
        // Idle entry with bus noise, then wake by strobe, by chip select, by reset
        for (int k = 0; k < 3; k++)
        begin
            pm_write(1'b0, 8'h02);
            busy = 1'b1; // Fresh idle count
            repeat (4) @(negedge mclk_in);
            busy = 1'b0;
            cs_n = 1'b1;
            move = 1'b1;
            wait_pd(1'b1, 300);
            check(n >= 56 && n < 300, 1'b1);
            held = mem_addr_out;
            repeat (6) @(negedge mclk_in);
            check(mem_addr_out, held);
            check(flash_sel_out, 1'b0);
            check(mem_standby_out, 1'b1);
            if (k == 0)
                busy = 1'b1;
            else if (k == 1)
                cs_n = 1'b0;
            else
                rst_n_in = 1'b0;
            wait_pd(1'b0, 12);
            check(power_down_flag_out, 1'b0);
            {busy, rst_n_in} = 2'b01;
            repeat (4) @(negedge mclk_in);
        end
        // Disabled feature never powers down
        pm_write(1'b0, 8'h00);
        cs_n = 1'b1;
        repeat (120) @(negedge mclk_in);
        check(power_down_flag_out, 1'b0);
        close_out();
    end
endmodule // bus_idle_power_manager_bench
bind bipm_top bipm_top_props #(.ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH)) u_props (
    .mclk_in, .rst_n_in, .port_d_bit0_in, .strobe_sel_in, .pm_first_wr_in, .pm_second_wr_in,
    .pm_wdata_in, .power_mode_reg_first_out, .power_mode_reg_second_out, .power_down_flag_out,
    .mem_addr_out, .pld_addr_out, .flash_sel_out, .sram_sel_out, .io_register_select_out,
    .mem_standby_out, .pld_full_speed_out, .first_access_slow_out);
`default_nettype wire
